//--- dv/ars_checker.sv
// Purpose: output timing and flag checks of the reference scaler
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   value check covers only the nominal characteristic of input 0
`timescale 1ns/10ps
`include "ars_regs.svh"

module ars_checker (
   input  wire logic                      clk,          // system clock
   input  wire logic                      reset_n,      // reset, active low
   input  wire logic                      sample_valid, // sample strobe
   input  wire logic signed [2:0][15:0]   sample,       // samples
   input  wire ars_pkg::ars_chcfg_t [2:0] ch_cfg,       // input settings
   input  wire ars_pkg::ars_limits_t      limits,       // ranges and bands
   input  wire logic                      freq_mode,    // range select
   input  wire logic signed [2:0][19:0]   ref_value,    // references
   input  wire logic                      ref_valid,    // reference pulse
   input  wire logic [2:0]                warn,         // warnings
   input  wire logic [2:0]                fault,        // fault requests
   input  wire logic [2:0]                stop_req      // stop requests
);
   logic lo_v;
   logic lo_c;
   // an element of a packed array is unsigned, so the sign is restored before comparing
   assign lo_v = $signed(sample[0]) < 16'sh0064;
   assign lo_c = $signed(sample[2]) < 16'sh00c8;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_take; sample_valid; endsequence
   sequence s_lone; sample_valid ##1 !sample_valid; endsequence
   property p_answer; s_take |=> ref_valid; endproperty
   property p_pulse; s_lone |=> !ref_valid; endproperty
   property p_hold; !sample_valid |=> $stable(ref_value) && $stable(warn); endproperty
   property p_fault; (fault & ~warn) == 3'h0 && (stop_req & ~fault) == 3'h0; endproperty
   property p_warn_v; s_take ##0 ch_cfg[0].mode == `ARS_MODE_LZ_W |=> warn[0] == $past(lo_v); endproperty
   property p_warn_c; s_take ##0 ch_cfg[2].mode == `ARS_MODE_LZ_W |=> warn[2] == $past(lo_c); endproperty
   property p_nowarn; s_take ##0 ch_cfg[1].mode == `ARS_MODE_BIP |=> !warn[1]; endproperty
   property p_stop; s_take ##0 ch_cfg[0].mode == `ARS_MODE_LZ_S && lo_v |=> stop_req[0] && fault[0]; endproperty
   property p_sat;
      s_take ##0 !freq_mode && ch_cfg[0] == {`ARS_MODE_BIP, 16'sh03e8, 16'sh0000} && $signed(sample[0]) >= 16'sh03e8
      |=> ref_value[0] == 20'($past(limits.pct_max));
   endproperty
   a_answer: assert property (p_answer) else $error("no reference pulse after strobe");
   a_pulse: assert property (p_pulse) else $error("reference pulse too long");
   a_hold: assert property (p_hold) else $error("outputs moved without strobe");
   a_fault: assert property (p_fault) else $error("fault or stop without warning");
   a_warn_v: assert property (p_warn_v) else $error("voltage low warning wrong");
   a_warn_c: assert property (p_warn_c) else $error("current low warning wrong");
   a_nowarn: assert property (p_nowarn) else $error("warning outside live zero");
   a_stop: assert property (p_stop) else $error("stop request missing");
   a_sat: assert property (p_sat) else $error("no saturation at upper end");
endmodule : ars_checker

//--- dv/ars_drive_model.sv
// Purpose: drive controller side, keeps the reference it was last handed
// Assumes: new references marked by the one-cycle pulse
// Notes:   only input 0 is consumed, the others are watched by the bench
`timescale 1ns/10ps

module ars_drive_model (
   input  wire logic                    clk,       // system clock
   input  wire logic                    reset_n,   // reset, active low
   input  wire logic signed [2:0][19:0] ref_value, // scaled references
   input  wire logic                    ref_valid, // new reference pulse
   output logic signed [19:0]           speed_ref  // reference in use
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         speed_ref <= 20'sh00000;
      else if (ref_valid)
         speed_ref <= ref_value[0];
   end
endmodule : ars_drive_model

//--- dv/tb_top.sv
// Purpose: self-checking bench of the reference scaler
// Assumes: percent 0..100.00 %, bands 2.00 % unless a scenario changes them
// Notes:   expectations are worked by hand from the characteristic
`timescale 1ns/10ps
`include "ars_regs.svh"

module tb_top;
   logic                      clk;
   logic                      reset_n;
   logic                      sample_valid;
   logic signed [2:0][15:0]   sample;
   ars_pkg::ars_chcfg_t [2:0] ch_cfg;
   ars_pkg::ars_limits_t      limits;
   logic                      freq_mode;
   logic signed [2:0][19:0]   ref_value;
   logic                      ref_valid;
   logic [2:0]                warn;
   logic [2:0]                fault;
   logic [2:0]                stop_req;
   logic signed [19:0]        speed_ref;
   int                        error_cnt;
   int                        n_tests;

   ars_top dut (.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid), .sample(sample), .ch_cfg(ch_cfg),
      .limits(limits), .freq_mode(freq_mode), .ref_value(ref_value), .ref_valid(ref_valid), .warn(warn),
      .fault(fault), .stop_req(stop_req));
   ars_drive_model partner (.clk(clk), .reset_n(reset_n), .ref_value(ref_value), .ref_valid(ref_valid),
      .speed_ref(speed_ref));

   task automatic conclude;
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   task automatic chk_v(input logic signed [19:0] got, input logic signed [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_v

   task automatic chk_b(input logic [2:0] got, input logic [2:0] exp);
      chk_v({17'h00000, got}, {17'h00000, exp});
   endtask : chk_b

   task automatic strobe(input logic signed [15:0] s0, s1, s2);
      @(posedge clk);
      sample_valid <= 1'b1;
      sample       <= {s2, s1, s0};
      @(posedge clk);
      sample_valid <= 1'b0;
      #1;
      chk_b({2'b00, ref_valid}, 3'h1);
   endtask : strobe

   // nominal settings; tweaks follow one edge later so no signal is driven twice at once
   task automatic defaults;
      @(posedge clk);
      for (int i = 0; i < 3; i++)
         ch_cfg[i] <= '{`ARS_MODE_BIP, (i == 2) ? 16'sh07d0 : 16'sh03e8, 16'sh0000};
      limits    <= '{17'h00000, 17'h02710, 17'h0015e, 17'h01388, 12'h0c8, 12'h0c8};
      freq_mode <= 1'b0;
   endtask : defaults

   task automatic t_nominal;
      defaults();
      strobe(16'sh01f4, 16'sh03e8, 16'sh03e8);
      chk_v(ref_value[0], 20'sh01388);
      chk_v(ref_value[1], 20'sh02710);
      chk_v(ref_value[2], 20'sh01388);
      // the drive model only loads on the edge after the pulse
      @(posedge clk);
      #1;
      chk_v(speed_ref, 20'sh01388);
      strobe(-16'sh03e8, 16'sh000a, -16'sh07d0);
      chk_v(ref_value[0], -20'sh02710);
      chk_v(ref_value[1], 20'sh00000);
      chk_v(ref_value[2], -20'sh02710);
      strobe(16'sh03e8, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], 20'sh02710);
   endtask : t_nominal

   task automatic t_hyst;
      defaults();
      @(posedge clk);
      limits.pct_min <= 17'h003e8;
      strobe(16'sh01f4, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], 20'sh0157c);
      strobe(-16'sh000a, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], 20'sh003e8);
      strobe(-16'sh001e, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], -20'sh00445);
      strobe(16'sh0005, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], -20'sh003e8);
   endtask : t_hyst

   task automatic t_adapt;
      defaults();
      @(posedge clk);
      ch_cfg[0] <= '{`ARS_MODE_BIP, 16'sh0320, 16'sh0064};
      strobe(-16'sh01f4, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], -20'sh02253);
      strobe(-16'sh0258, 16'sh0000, 16'sh0000);
      chk_v(ref_value[0], -20'sh02710);
      @(posedge clk);
      ch_cfg[0] <= '{`ARS_MODE_BIP, 16'sh07d0, 16'sh0000};
      ch_cfg[2] <= '{`ARS_MODE_BIP, 16'sh0bb8, 16'sh0000};
      strobe(16'sh01f4, 16'sh0000, 16'sh03e8);
      chk_v(ref_value[0], 20'sh01388);
      chk_v(ref_value[2], 20'sh01388);
   endtask : t_adapt

   task automatic t_modes;
      logic [8:0]         md [5] = '{`ARS_MODE_UNI, `ARS_MODE_ABS, `ARS_MODE_BIP_INV, `ARS_MODE_UNI_INV,
                                     `ARS_MODE_ABS_INV};
      logic signed [15:0] sm [5] = '{-16'sh01f4, -16'sh01f4, 16'sh03e8, -16'sh01f4, -16'sh03e8};
      logic signed [19:0] ex [5] = '{20'sh00000, 20'sh01388, 20'sh00000, 20'sh02710, 20'sh00000};
      defaults();
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         ch_cfg[0].mode <= md[i];
         strobe(sm[i], 16'sh0000, 16'sh0000);
         chk_v(ref_value[0], ex[i]);
      end
   endtask : t_modes

   task automatic t_livezero;
      logic [8:0] md [6] = '{`ARS_MODE_LZ_W, `ARS_MODE_LZ_W_INV, `ARS_MODE_LZ_E, `ARS_MODE_LZ_E_INV,
                             `ARS_MODE_LZ_S, `ARS_MODE_LZ_S_INV};
      defaults();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         ch_cfg[0] <= '{md[i], 16'sh012c, -16'sh01f4};
         ch_cfg[2] <= '{md[i], 16'sh012c, -16'sh01f4};
         strobe(16'sh0258, 16'sh0000, 16'sh04b0);
         chk_v(ref_value[0], 20'sh01388);
         chk_v(ref_value[2], 20'sh01388);
         chk_b(warn, 3'h0);
         strobe(16'sh0032, 16'sh0000, 16'sh0096);
         chk_b(warn, 3'h5);
         chk_b(fault, (i >= 2) ? 3'h5 : 3'h0);
         chk_b(stop_req, (i >= 4) ? 3'h5 : 3'h0);
         chk_v(ref_value[0], i[0] ? 20'sh02710 : 20'sh00000);
      end
      strobe(16'sh0064, 16'sh0000, 16'sh00c8);
      chk_b(warn, 3'h0);
   endtask : t_livezero

   task automatic t_freq_band;
      defaults();
      @(posedge clk);
      freq_mode <= 1'b1;
      strobe(16'sh03e8, -16'sh03e8, 16'sh07d0);
      chk_v(ref_value[0], 20'sh01388);
      chk_v(ref_value[1], -20'sh01388);
      @(posedge clk);
      freq_mode        <= 1'b0;
      limits.zero_band <= 12'hbb8;
      limits.end_band  <= 12'h9c4;
      strobe(16'sh00f0, 16'sh02ee, 16'sh0000);
      chk_v(ref_value[0], 20'sh00000);
      chk_v(ref_value[1], 20'sh02710);
   endtask : t_freq_band

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #40000;
      error_cnt++;
      conclude();
   end

   initial begin
      reset_n      = 1'b0;
      sample_valid = 1'b0;
      sample       = '0;
      ch_cfg       = '0;
      limits       = '0;
      freq_mode    = 1'b0;
      error_cnt    = 0;
      n_tests      = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_nominal();
      t_hyst();
      t_adapt();
      t_modes();
      t_livezero();
      t_freq_band();
      conclude();
   end
endmodule : tb_top

bind ars_top ars_checker u_chk (.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid), .sample(sample),
   .ch_cfg(ch_cfg), .limits(limits), .freq_mode(freq_mode), .ref_value(ref_value), .ref_valid(ref_valid),
   .warn(warn), .fault(fault), .stop_req(stop_req));

//--- rtl/ars_chan.sv
// Purpose: per-input characteristic: adaptation, tolerance bands and linear mapping
// Assumes: sample and settings stable in the cycle they are used
// Notes:   purely combinational; hysteresis and sign are applied by the caller
`timescale 1ns/10ps
`include "ars_regs.svh"

module ars_chan (
   input  wire logic signed [15:0] sample,       // converter sample
   input  wire logic               is_curr,      // input is the current input
   input  wire logic               live_zero,    // live-zero mode selected
   input  wire logic               invert,       // inverted characteristic
   input  wire logic signed [15:0] upper,        // user upper end point
   input  wire logic signed [15:0] zero,         // user zero point
   input  wire logic        [11:0] zero_band,    // zero band width
   input  wire logic        [11:0] end_band,     // end band width
   input  wire logic        [16:0] lo_val,       // mapped minimum
   input  wire logic        [16:0] hi_val,       // mapped maximum
   output logic             [16:0] val,          // mapped magnitude
   output logic             [16:0] zval,         // magnitude inside zero band
   output logic                    above_pos,    // beyond positive zero band
   output logic                    below_neg,    // beyond negative zero band
   output logic                    neg_side,     // input below zero point
   output logic                    low_warn      // live-zero wire-break level
);

   logic signed [31:0] s, fs, zp, up, lower, x, mag, span, zb, eb, act, lo, hi, frac;
   logic signed [47:0] num;

   function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                input logic signed [31:0] lo_l,
                                                input logic signed [31:0] hi_l);
      clamp = (v < lo_l) ? lo_l : ((v > hi_l) ? hi_l : v);
   endfunction : clamp

   always_comb begin
      s  = 32'(sample);
      lo = 32'($signed({15'h0000, lo_val}));
      hi = 32'($signed({15'h0000, hi_val}));
      fs = is_curr ? `ARS_FS_CURR : `ARS_FS_VOLT;
      // live-zero spans replace the user adaptation entirely
      if (live_zero) begin
         zp = is_curr ? `ARS_LZ_ZERO_CURR : `ARS_LZ_ZERO_VOLT;
         up = fs;
      end else if (is_curr) begin
         zp = clamp(32'(zero), -`ARS_CZP_LIM, `ARS_CZP_LIM);
         up = clamp(32'(upper), `ARS_CUP_MIN, `ARS_CUP_MAX);
      end else begin
         zp = clamp(32'(zero), -`ARS_VZP_LIM, `ARS_VZP_LIM);
         up = clamp(32'(upper), `ARS_VUP_MIN, `ARS_VUP_MAX);
      end
      lower    = 32'sh2 * zp - up;
      x        = s - zp;
      neg_side = x < 32'sh0;
      mag      = neg_side ? -x : x;
      span     = neg_side ? (zp - lower) : (up - zp);
      zb  = clamp(32'($signed({20'h00000, zero_band})), 32'sh0, `ARS_BAND_MAX) * fs / `ARS_BAND_SCALE;
      eb  = clamp(32'($signed({20'h00000, end_band})), 32'sh0, `ARS_BAND_MAX) * fs / `ARS_BAND_SCALE;
      act = span - eb - zb;
      num = 48'(mag - zb) * 48'(hi - lo);
      // a misconfigured span (zero point too close to the end point) saturates rather than divides by zero
      if (mag <= zb)
         frac = lo;
      else if (act <= 32'sh0 || mag >= span - eb)
         frac = hi;
      else
         frac = lo + 32'(num / 48'(act));
      val       = invert ? 17'(hi + lo - frac) : 17'(frac);
      zval      = invert ? hi_val : lo_val;
      above_pos = !neg_side && (mag > zb);
      below_neg = neg_side && (mag > zb);
      low_warn  = live_zero && (s < (is_curr ? `ARS_WARN_CURR : `ARS_WARN_VOLT));
   end

endmodule : ars_chan

//--- rtl/ars_pkg.sv
// Purpose: types of the analog reference scaler
// Assumes: three inputs, two voltage and one current
// Notes:   constants live in ars_regs.svh
package ars_pkg;

   typedef enum logic [2:0] {
      ARS_CURVE_BIP = 3'h1,
      ARS_CURVE_UNI = 3'h2,
      ARS_CURVE_ABS = 3'h4
   } ars_curve_t;

   typedef struct packed {
      logic        [8:0]  mode;
      logic signed [15:0] upper;
      logic signed [15:0] zero;
   } ars_chcfg_t;

   typedef struct packed {
      logic        [16:0] pct_min;
      logic        [16:0] pct_max;
      logic        [16:0] freq_min;
      logic        [16:0] freq_max;
      logic        [11:0] zero_band;
      logic        [11:0] end_band;
   } ars_limits_t;

   typedef struct packed {
      logic [2:0]               side_neg;
      logic [2:0][19:0]         value;
      logic [2:0]               warn;
      logic [2:0]               fault;
      logic [2:0]               stop;
      logic                     valid;
   } ars_state_t;

endpackage : ars_pkg

//--- rtl/ars_regs.svh
// Purpose: constants of the analog reference scaler (fixed-point scales, limits, mode codes)
// Assumes: voltage in 0.01 V, current in 0.01 mA, percent and band width in 0.01 %, frequency in 0.01 Hz
// Notes:   all arithmetic constants are 32-bit signed to match the datapath
`ifndef ARS_REGS_SVH
`define ARS_REGS_SVH

`define ARS_FS_VOLT        32'sh000003e8
`define ARS_FS_CURR        32'sh000007d0
`define ARS_LZ_ZERO_VOLT   32'sh000000c8
`define ARS_LZ_ZERO_CURR   32'sh00000190
`define ARS_WARN_VOLT      32'sh00000064
`define ARS_WARN_CURR      32'sh000000c8
`define ARS_BAND_SCALE     32'sh00002710
`define ARS_BAND_MAX       32'sh000009c4
`define ARS_BAND_DEF       32'sh000000c8
`define ARS_PCT_MAX        32'sh00007530
`define ARS_PCT_MAX_DEF    32'sh00002710
`define ARS_PCT_MIN_DEF    32'sh00000000
`define ARS_FREQ_MAX       32'sh0001869f
`define ARS_VUP_MIN        (-32'sh00000258)
`define ARS_VUP_MAX        32'sh000003e8
`define ARS_VZP_LIM        32'sh00000320
`define ARS_CUP_MIN        (-32'sh000004b0)
`define ARS_CUP_MAX        32'sh000007d0
`define ARS_CZP_LIM        32'sh00000640

`define ARS_MODE_BIP       9'h001
`define ARS_MODE_UNI       9'h002
`define ARS_MODE_ABS       9'h003
`define ARS_MODE_BIP_INV   9'h00b
`define ARS_MODE_UNI_INV   9'h00c
`define ARS_MODE_ABS_INV   9'h00d
`define ARS_MODE_LZ_W      9'h066
`define ARS_MODE_LZ_W_INV  9'h070
`define ARS_MODE_LZ_E      9'h0ca
`define ARS_MODE_LZ_E_INV  9'h0d4
`define ARS_MODE_LZ_S      9'h12e
`define ARS_MODE_LZ_S_INV  9'h138

`endif

//--- rtl/ars_top.sv
// Purpose: analog reference scaler, three converter inputs onto a percent or frequency reference
// Assumes: samples arrive from converter logic on clk, one strobe for all three inputs
// Notes:   outputs are registered and update one cycle after each sample strobe
//
// Overview of operation
// - In percent operation the output is the input expressed as a percentage of the motor's rated quantity.
// - Both the positive and negative maximum of the curve map to the maximum percent, at most 300.00 %, nominally 100.00 %.
// - Both the positive and negative minimum of the curve map to the minimum percent, from 0.00 %, nominally 0.00 %.
// - Tolerance bands sit at the upper end, lower end and zero point, with the zero band and end band settings shared by all inputs.
// - On the bipolar curve the zero band holds the last side's minimum until the opposite band edge is crossed.
// - The zero band width runs from 0 to 25.00 % of full scale, nominally 2.00 %.
// - The end band width runs from 0.0 % to 25.0 % of full scale, nominally two percent.
// - Each input's upper end point and zero point are user set so spans other than 0-10 V or 0-20 mA fit.
// - Voltage inputs take an upper end point of -6.00 V to 10.00 V and a zero point of -8.00 V to 8.00 V.
// - The current input takes an upper end point of -12.00 mA to 20.00 mA and a zero point of -16.00 mA to 16.00 mA.
// - The lower end point is twice the zero point minus the upper end point.
// - Live-zero modes (2-10 V, 4-20 mA) ignore the end point and zero point settings.
// - In live-zero modes a warning rises whenever a voltage input is below 1 V or the current input below 2 mA.
// - In frequency operation the curve's maxima map to the maximum and its minima to the minimum frequency.
`timescale 1ns/10ps
`include "ars_regs.svh"

module ars_top (
   input  wire logic                           clk,          // system clock, 250 MHz
   input  wire logic                           reset_n,      // asynchronous reset, active low
   input  wire logic                           sample_valid, // one-cycle strobe, samples valid
   input  wire logic signed [2:0][15:0]        sample,       // converter samples, index 2 is current
   input  wire ars_pkg::ars_chcfg_t [2:0]      ch_cfg,       // per-input mode and adaptation
   input  wire ars_pkg::ars_limits_t           limits,       // output range and band widths
   input  wire logic                           freq_mode,    // 1 frequency range, 0 percent range
   output logic signed [2:0][19:0]             ref_value,    // scaled reference per input
   output logic                                ref_valid,    // one-cycle pulse, new references
   output logic        [2:0]                   warn,         // live-zero low level warning
   output logic        [2:0]                   fault,        // low level fault request
   output logic        [2:0]                   stop_req      // low level stop-and-hold request
);

   ars_pkg::ars_state_t state_r;
   ars_pkg::ars_state_t state_nxt;

   logic [16:0] lo_val;
   logic [16:0] hi_val;

   ars_pkg::ars_curve_t [2:0] curve;
   logic [2:0]                invert;
   logic [2:0]                live_zero;
   logic [2:0]                fault_en;
   logic [2:0]                stop_en;
   logic [2:0][16:0]          val;
   logic [2:0][16:0]          zval;
   logic [2:0]                above_pos;
   logic [2:0]                below_neg;
   logic [2:0]                neg_side;
   logic [2:0]                low_warn;
   logic [2:0]                side_nxt;
   logic signed [2:0][19:0]   value_nxt;

   function automatic logic [16:0] lim(input logic [16:0] v, input logic signed [31:0] top);
      lim = (32'($signed({15'h0000, v})) > top) ? 17'(top) : v;
   endfunction : lim

   // one range pair for all inputs; percent and frequency are never mixed
   always_comb begin
      if (freq_mode) begin
         lo_val = lim(limits.freq_min, `ARS_FREQ_MAX);
         hi_val = lim(limits.freq_max, `ARS_FREQ_MAX);
      end else begin
         lo_val = lim(limits.pct_min, `ARS_PCT_MAX);
         hi_val = lim(limits.pct_max, `ARS_PCT_MAX);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ch
         // unknown codes fall back to the plain bipolar curve
         always_comb begin
            curve[gi]     = ars_pkg::ARS_CURVE_BIP;
            invert[gi]    = 1'b0;
            live_zero[gi] = 1'b0;
            fault_en[gi]  = 1'b0;
            stop_en[gi]   = 1'b0;
            case (ch_cfg[gi].mode)
               `ARS_MODE_BIP: begin
                  curve[gi] = ars_pkg::ARS_CURVE_BIP;
               end
               `ARS_MODE_UNI: begin
                  curve[gi] = ars_pkg::ARS_CURVE_UNI;
               end
               `ARS_MODE_ABS: begin
                  curve[gi] = ars_pkg::ARS_CURVE_ABS;
               end
               `ARS_MODE_BIP_INV: begin
                  curve[gi]  = ars_pkg::ARS_CURVE_BIP;
                  invert[gi] = 1'b1;
               end
               `ARS_MODE_UNI_INV: begin
                  curve[gi]  = ars_pkg::ARS_CURVE_UNI;
                  invert[gi] = 1'b1;
               end
               `ARS_MODE_ABS_INV: begin
                  curve[gi]  = ars_pkg::ARS_CURVE_ABS;
                  invert[gi] = 1'b1;
               end
               `ARS_MODE_LZ_W, `ARS_MODE_LZ_W_INV: begin
                  curve[gi]     = ars_pkg::ARS_CURVE_UNI;
                  invert[gi]    = (ch_cfg[gi].mode == `ARS_MODE_LZ_W_INV);
                  live_zero[gi] = 1'b1;
               end
               `ARS_MODE_LZ_E, `ARS_MODE_LZ_E_INV: begin
                  curve[gi]     = ars_pkg::ARS_CURVE_UNI;
                  invert[gi]    = (ch_cfg[gi].mode == `ARS_MODE_LZ_E_INV);
                  live_zero[gi] = 1'b1;
                  fault_en[gi]  = 1'b1;
               end
               `ARS_MODE_LZ_S, `ARS_MODE_LZ_S_INV: begin
                  curve[gi]     = ars_pkg::ARS_CURVE_UNI;
                  invert[gi]    = (ch_cfg[gi].mode == `ARS_MODE_LZ_S_INV);
                  live_zero[gi] = 1'b1;
                  fault_en[gi]  = 1'b1;
                  stop_en[gi]   = 1'b1;
               end
               default: begin
                  curve[gi] = ars_pkg::ARS_CURVE_BIP;
               end
            endcase
         end

         ars_chan u_chan (
            .sample    (sample[gi]),
            .is_curr   (gi == 2),
            .live_zero (live_zero[gi]),
            .invert    (invert[gi]),
            .upper     (ch_cfg[gi].upper),
            .zero      (ch_cfg[gi].zero),
            .zero_band (limits.zero_band),
            .end_band  (limits.end_band),
            .lo_val    (lo_val),
            .hi_val    (hi_val),
            .val       (val[gi]),
            .zval      (zval[gi]),
            .above_pos (above_pos[gi]),
            .below_neg (below_neg[gi]),
            .neg_side  (neg_side[gi]),
            .low_warn  (low_warn[gi])
         );

         // the side flips only when the far band edge is crossed, which gives the zero-band hysteresis
         always_comb begin
            side_nxt[gi] = state_r.side_neg[gi];
            if (above_pos[gi])
               side_nxt[gi] = 1'b0;
            else if (below_neg[gi])
               side_nxt[gi] = 1'b1;
            case (curve[gi])
               ars_pkg::ARS_CURVE_BIP: begin
                  if (above_pos[gi] || below_neg[gi])
                     value_nxt[gi] = neg_side[gi] ? -20'($signed({3'h0, val[gi]})) : 20'($signed({3'h0, val[gi]}));
                  else
                     value_nxt[gi] = side_nxt[gi] ? -20'($signed({3'h0, zval[gi]})) : 20'($signed({3'h0, zval[gi]}));
               end
               ars_pkg::ARS_CURVE_UNI: begin
                  // below the zero point a unipolar curve stays at its zero-band value
                  value_nxt[gi] = neg_side[gi] ? 20'($signed({3'h0, zval[gi]})) : 20'($signed({3'h0, val[gi]}));
               end
               ars_pkg::ARS_CURVE_ABS: begin
                  value_nxt[gi] = 20'($signed({3'h0, val[gi]}));
               end
               default: begin
                  value_nxt[gi] = 20'($signed({3'h0, val[gi]}));
               end
            endcase
         end
      end
   endgenerate

   always_comb begin
      state_nxt       = state_r;
      state_nxt.valid = 1'b0;
      if (sample_valid) begin
         state_nxt.valid    = 1'b1;
         state_nxt.side_neg = side_nxt;
         state_nxt.value    = value_nxt;
         // warnings follow the sample every strobe, independent of drive release
         state_nxt.warn     = low_warn;
         state_nxt.fault    = low_warn & fault_en;
         state_nxt.stop     = low_warn & stop_en;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         state_r <= '0;
      else
         state_r <= state_nxt;
   end

   assign ref_value = state_r.value;
   assign ref_valid = state_r.valid;
   assign warn      = state_r.warn;
   assign fault     = state_r.fault;
   assign stop_req  = state_r.stop;

endmodule : ars_top
